// *** inc/intr_flag_map.svh ***
`ifndef INTR_FLAG_MAP_SVH
`define INTR_FLAG_MAP_SVH
// register byte addresses
`define ADDR_FLAGS     12'h000
`define ADDR_REQUEST   12'h004
`define ADDR_STATUS    12'h008
`define ADDR_TRAP      12'h00c
// flag register fields
`define FLAG_ACCEPT_BIT 6
`define FLAG_STACK_BIT  7
`define FLAG_RSVD_BIT   11
`define FLAG_PRIO_LSB   12
`define FLAG_PRIO_MSB   14
// reset values
`define RST_ACCEPT      1'b0
`define RST_STACK       1'b0
`define RST_PRIO        3'h0
// trap numbers that force the interrupt stack
`define TRAP_STACK_MAX  6'h1f
// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// *** inc/intr_flag_pkg.sv ***
package intr_flag_pkg;
  typedef logic [2:0] prio_t;
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_RESP = 3'b010,
    RD_HOLD = 3'b100
  } rd_state_t;
endpackage

// *** inc/accept_if.sv ***
`timescale 1ns/1ps
interface accept_if;
  logic                   accept_flag;
  intr_flag_pkg::prio_t   level;
  logic                   req_valid;
  logic                   req_nonmask;
  intr_flag_pkg::prio_t   req_prio;
  logic                   take;
  modport judge (input accept_flag, level, req_valid, req_nonmask, req_prio, output take);
  modport owner (output accept_flag, level, req_valid, req_nonmask, req_prio, input take);
endinterface

// *** rtl/accept_judge.sv ***
`timescale 1ns/1ps
module accept_judge (
  accept_if.judge a
);
  // maskable needs both the flag and a strictly higher priority
  always_comb begin
    if (!a.req_valid) begin
      a.take = 1'b0;
    end else if (a.req_nonmask) begin
      a.take = 1'b1;
    end else begin
      a.take = a.accept_flag && (a.req_prio > a.level);
    end
  end
endmodule

// *** rtl/intr_flag_unit.sv ***
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "intr_flag_map.svh"
// Operation
// - accept flag low blocks maskable requests
// - any acknowledge clears accept flag
// - stack flag selects interrupt or user stack
// - hardware acknowledge or low trap clears stack flag
// - priority level is three bits
// - maskable request priority must exceed level
// - reserved bit reads undefined, write zero
// - low reset reinitialises flags
module intr_flag_unit (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output      logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output      logic                 s_axi_wready,
  output      logic [1:0]           s_axi_bresp,
  output      logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output      logic                 s_axi_arready,
  output      logic [31:0]          s_axi_rdata,
  output      logic [1:0]           s_axi_rresp,
  output      logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 irq_valid,
  input  wire logic                 irq_nonmask,
  input  wire intr_flag_pkg::prio_t irq_prio,
  output      logic                 irq_ack,
  input  wire logic                 trap_exec,
  input  wire logic [5:0]           trap_num,
  input  wire logic                 flags_load,
  input  wire logic [15:0]          flags_wdata,
  output      logic [15:0]          flags_out,
  output      logic                 use_user_stack,
  output      logic                 stack_sel_isp
);

  ////////////////////////////////////////////////////////////////////////
  logic                 accept_reg;
  logic                 stack_reg;
  intr_flag_pkg::prio_t prio_reg;
  logic                 rsvd_reg;
  logic                 ack_seen_reg;
  intr_flag_pkg::prio_t last_prio_reg;
  logic                 aw_held_reg;
  logic                 w_held_reg;
  logic [11:0]          awaddr_reg;
  logic [31:0]          wdata_reg;
  logic [3:0]           wstrb_reg;
  intr_flag_pkg::rd_state_t rd_state_reg;
  logic                 wr_fire;
  logic [11:0]          wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;
  logic                 sw_flag_write;
  logic                 take;
  logic                 trap_low;
  accept_if             acc ();

  assign acc.accept_flag = accept_reg;
  assign acc.level       = prio_reg;
  assign acc.req_valid   = irq_valid;
  assign acc.req_nonmask = irq_nonmask;
  assign acc.req_prio    = irq_prio;
  assign take            = acc.take;
  assign irq_ack         = take;

  accept_judge judge_i (
    .a (acc)
  );

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  assign wr_fire = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held_reg || (s_axi_wvalid && s_axi_wready));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_addr == `ADDR_FLAGS || wr_addr == `ADDR_STATUS) ?
                      `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only the low two lanes carry flag bits
  assign sw_flag_write = wr_fire && (wr_addr == `ADDR_FLAGS) && wr_strb[0] && wr_strb[1];

  ////////////////////////////////////////////////////////////////////////
  // flag register
  assign trap_low = trap_exec && (trap_num <= `TRAP_STACK_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accept_reg <= `RST_ACCEPT;
    end else if (take) begin
      accept_reg <= 1'b0;
    end else if (flags_load) begin
      accept_reg <= flags_wdata[`FLAG_ACCEPT_BIT];
    end else if (sw_flag_write) begin
      accept_reg <= wr_data[`FLAG_ACCEPT_BIT];
    end
  end

  // hardware clear beats any software load in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_reg <= `RST_STACK;
    end else if (take || trap_low) begin
      stack_reg <= 1'b0;
    end else if (flags_load) begin
      stack_reg <= flags_wdata[`FLAG_STACK_BIT];
    end else if (sw_flag_write) begin
      stack_reg <= wr_data[`FLAG_STACK_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_reg <= `RST_PRIO;
      rsvd_reg <= 1'b0;
    end else if (flags_load) begin
      prio_reg <= flags_wdata[`FLAG_PRIO_MSB:`FLAG_PRIO_LSB];
      rsvd_reg <= flags_wdata[`FLAG_RSVD_BIT];
    end else if (sw_flag_write) begin
      prio_reg <= wr_data[`FLAG_PRIO_MSB:`FLAG_PRIO_LSB];
      rsvd_reg <= wr_data[`FLAG_RSVD_BIT];
    end
  end

  // sticky acknowledge status; set wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_seen_reg  <= 1'b0;
      last_prio_reg <= 3'h0;
    end else if (take) begin
      ack_seen_reg  <= 1'b1;
      last_prio_reg <= irq_prio;
    end else if (wr_fire && wr_addr == `ADDR_STATUS && wr_strb[0] && wr_data[0]) begin
      ack_seen_reg <= 1'b0;
    end
  end

  always_comb begin
    flags_out = 16'h0000;
    flags_out[`FLAG_ACCEPT_BIT] = accept_reg;
    flags_out[`FLAG_STACK_BIT]  = stack_reg;
    // reserved bit echoes last write; software must not rely on it
    flags_out[`FLAG_RSVD_BIT]   = rsvd_reg;
    flags_out[`FLAG_PRIO_MSB:`FLAG_PRIO_LSB] = prio_reg;
  end

  assign use_user_stack = stack_reg;
  assign stack_sel_isp  = !stack_reg;

  ////////////////////////////////////////////////////////////////////////
  // read channel
  assign s_axi_arready = (rd_state_reg == intr_flag_pkg::RD_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= intr_flag_pkg::RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      unique case (rd_state_reg)
        intr_flag_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_reg <= intr_flag_pkg::RD_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            unique case (s_axi_araddr)
              `ADDR_FLAGS:   s_axi_rdata <= {16'h0000, flags_out};
              `ADDR_REQUEST: s_axi_rdata <= {24'h000000, irq_prio, 3'h0, irq_nonmask,
                                             irq_valid};
              `ADDR_STATUS:  s_axi_rdata <= {24'h000000, 1'b0, last_prio_reg, 2'h0,
                                             take, ack_seen_reg};
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RESP_SLVERR;
              end
            endcase
          end
        end
        intr_flag_pkg::RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_reg <= intr_flag_pkg::RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state_reg <= intr_flag_pkg::RD_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** sim/intr_flag_unit_asserts.sv ***
`timescale 1ns/1ps
module intr_flag_unit_asserts (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 irq_valid,
  input wire logic                 irq_nonmask,
  input wire intr_flag_pkg::prio_t irq_prio,
  input wire logic                 irq_ack,
  input wire logic                 trap_exec,
  input wire logic [5:0]           trap_num,
  input wire logic [15:0]          flags_out,
  input wire logic                 use_user_stack,
  input wire logic                 stack_sel_isp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_mask_block: assert property (irq_ack && !irq_nonmask |-> flags_out[6])
    else $error("ack with accept flag low");
  chk_prio_above: assert property (irq_ack && !irq_nonmask |-> irq_prio > flags_out[14:12])
    else $error("ack at or below level");
  chk_ack_exact: assert property (irq_valid && !irq_nonmask |->
    irq_ack == (flags_out[6] && irq_prio > flags_out[14:12]))
    else $error("maskable ack mismatch");
  chk_ack_clears: assert property (irq_ack |=> !flags_out[6])
    else $error("accept flag kept after ack");
  chk_ack_stack: assert property ($past(irq_ack) |-> !use_user_stack)
    else $error("stack flag kept after ack");
  chk_trap_stack: assert property (trap_exec && trap_num <= 6'h1f |=> !use_user_stack)
    else $error("stack flag kept after trap");
  chk_stack_pair: assert property (use_user_stack == flags_out[7] &&
    stack_sel_isp != use_user_stack)
    else $error("stack select mismatch");
  chk_reset_flags: assert property (disable iff (1'b0) !aresetn |=> flags_out == 16'h0000)
    else $error("flags not cleared by reset");
endmodule

// *** sim/irq_source_model.sv ***
`timescale 1ns/1ps
module irq_source_model (
  input  wire logic                 aclk,
  input  wire logic                 want,
  input  wire logic                 want_nm,
  input  wire intr_flag_pkg::prio_t want_prio,
  input  wire logic                 irq_ack,
  output      logic                 irq_valid,
  output      logic                 irq_nonmask,
  output      intr_flag_pkg::prio_t irq_prio
);
  initial begin
    irq_valid   = 1'b0;
    irq_nonmask = 1'b0;
    irq_prio    = 3'h0;
  end
  // sequencer withdraws the request the edge after ack; idle priority toggles
  always @(posedge aclk) begin
    irq_valid   <= want && !irq_ack;
    irq_nonmask <= want_nm;
    irq_prio    <= want ? want_prio : ~irq_prio;
  end
endmodule

// *** sim/test_interrupt_accept_flag_logic.sv ***
`timescale 1ns/1ps
`include "intr_flag_map.svh"
module test_interrupt_accept_flag_logic;
  typedef struct packed {logic [15:0] f; logic nm; logic [2:0] p; logic a;} row_t;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq_valid, irq_nonmask, irq_ack, trap_exec = 0;
  logic flags_load = 0, use_user_stack, stack_sel_isp, want = 0, want_nm = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [5:0]  trap_num = 6'h00;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [15:0] flags_wdata = 16'h0000, flags_out;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  intr_flag_pkg::prio_t irq_prio, want_prio = 3'h0;
  int   n_errors = 0, comparisons = 0;
  row_t rows [6] = '{'{16'h0040, 1'b0, 3'h1, 1'b1}, '{16'h0080, 1'b0, 3'h7, 1'b0},
                     '{16'h30c0, 1'b0, 3'h3, 1'b0}, '{16'h30c0, 1'b0, 3'h4, 1'b1},
                     '{16'h7040, 1'b0, 3'h7, 1'b0}, '{16'h00c0, 1'b1, 3'h0, 1'b1}};
  intr_flag_unit u_dut (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axi_awaddr   (s_axi_awaddr),
    .s_axi_awvalid  (s_axi_awvalid),
    .s_axi_awready  (s_axi_awready),
    .s_axi_wdata    (s_axi_wdata),
    .s_axi_wstrb    (s_axi_wstrb),
    .s_axi_wvalid   (s_axi_wvalid),
    .s_axi_wready   (s_axi_wready),
    .s_axi_bresp    (s_axi_bresp),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_rresp    (s_axi_rresp),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .irq_valid      (irq_valid),
    .irq_nonmask    (irq_nonmask),
    .irq_prio       (irq_prio),
    .irq_ack        (irq_ack),
    .trap_exec      (trap_exec),
    .trap_num       (trap_num),
    .flags_load     (flags_load),
    .flags_wdata    (flags_wdata),
    .flags_out      (flags_out),
    .use_user_stack (use_user_stack),
    .stack_sel_isp  (stack_sel_isp)
  );
  irq_source_model u_src (.aclk(aclk), .want(want), .want_nm(want_nm), .want_prio(want_prio),
    .irq_ack(irq_ack), .irq_valid(irq_valid), .irq_nonmask(irq_nonmask), .irq_prio(irq_prio));
  initial begin
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task axi_rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task load(input logic [15:0] f);
    @(posedge aclk);
    flags_load  <= 1'b1;
    flags_wdata <= f;
    @(posedge aclk);
    flags_load  <= 1'b0;
  endtask
  task end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check(32'(flags_out), 32'h0);
    foreach (rows[i]) begin
      axi_wr(`ADDR_FLAGS, {16'h0000, rows[i].f});
      axi_rd(`ADDR_FLAGS);
      check(rd, {16'h0000, rows[i].f});
      check(32'({stack_sel_isp, use_user_stack}), 32'({~rows[i].f[7], rows[i].f[7]}));
      @(posedge aclk);
      want      <= 1'b1;
      want_nm   <= rows[i].nm;
      want_prio <= rows[i].p;
      @(posedge aclk);
      @(negedge aclk);
      check(32'(irq_ack), 32'(rows[i].a));
      @(posedge aclk);
      want <= 1'b0;
      @(negedge aclk);
      check(32'(flags_out), 32'(rows[i].a ? rows[i].f & 16'hff3f : rows[i].f));
    end
    // last row was a non-maskable ack at priority 0: sticky bit set, then cleared by write-one
    axi_rd(`ADDR_STATUS);
    check(rd, 32'h0000_0001);
    axi_wr(`ADDR_STATUS, 32'h0000_0001);
    check(32'(resp), 32'(`RESP_OKAY));
    axi_rd(`ADDR_STATUS);
    check(rd, 32'h0000_0000);
    axi_rd(`ADDR_TRAP);
    check(32'(resp), 32'(`RESP_SLVERR));
    axi_wr(`ADDR_REQUEST, 32'h0);
    check(32'(resp), 32'(`RESP_SLVERR));
    // trap 31 is the last number that moves to the interrupt stack
    for (int i = 0; i < 2; i++) begin
      load(16'h0080);
      @(posedge aclk);
      trap_exec <= 1'b1;
      trap_num  <= 6'h1f + 6'(i);
      @(posedge aclk);
      trap_exec <= 1'b0;
      @(negedge aclk);
      check(32'(use_user_stack), 32'(i[0]));
    end
    load(16'h70c0);
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check(32'(flags_out), 32'h0);
    end_of_test();
  end
endmodule
bind intr_flag_unit intr_flag_unit_asserts u_chk (
  .aclk           (aclk),
  .aresetn        (aresetn),
  .irq_valid      (irq_valid),
  .irq_nonmask    (irq_nonmask),
  .irq_prio       (irq_prio),
  .irq_ack        (irq_ack),
  .trap_exec      (trap_exec),
  .trap_num       (trap_num),
  .flags_out      (flags_out),
  .use_user_stack (use_user_stack),
  .stack_sel_isp  (stack_sel_isp)
);
